// File: logic/pmtp_params.svh
// Constants for the MAC-facing transmit port: clock rates, dividers,
// strap layout and the index of the last link unit of each byte.
// Assumes the system clock runs at PMTP_CLK_HZ.
// Summary of operation
// - MII mode: device drives 25/2.5 MHz transmit clock.
// - MII transmit clock phase locked to system clock.
// - RMII mode: transmit clock pin unused, reference clock times.
// - RGMII mode: MAC sources 25/2.5 MHz transmit clock.
// - Transmit enable high on rising edge flags data.
// - RGMII control: enable on rise, error on fall.
// - MII nibble captured on rising transmit clock edge.
// - RMII dibit captured on rising reference clock edge.
// - Straps latched at reset; undriven straps take defaults.
`ifndef PMTP_PARAMS_SVH
`define PMTP_PARAMS_SVH

`define PMTP_CLK_HZ      125000000
`define PMTP_RATE_100_HZ 25000000
`define PMTP_RATE_10_HZ  2500000
`define PMTP_DIV_100     (`PMTP_CLK_HZ / `PMTP_RATE_100_HZ)
`define PMTP_DIV_10      (`PMTP_CLK_HZ / `PMTP_RATE_10_HZ)
`define PMTP_DIV_W       6

// Strap bits: [1:0] interface mode, [2] speed (1 = 100 Mbps).
`define PMTP_STRAP_W       3
`define PMTP_STRAP_MODE_LO 0
`define PMTP_STRAP_SPEED   2
`define PMTP_STRAP_DEFAULT 3'h4
`define PMTP_MODE_RMII     2'h1
`define PMTP_MODE_RGMII    2'h2
`define PMTP_STRAP_WAIT    2'h2

// Link clock rises counted after latching before the link side leaves
// reset; the count is one less than the number of rises.
`define PMTP_LINK_RST_EDGES 3'h4

`define PMTP_LAST_MII   2'h1
`define PMTP_LAST_RMII  2'h3
`define PMTP_LAST_RGMII 2'h0

`endif

// File: logic/pmtp_pkg.sv
// Types shared by both ends of the MAC-facing transmit port.
// Assumes nothing of its surroundings.
package pmtp_pkg;

  typedef enum logic [1:0] {
    PMTP_MII,
    PMTP_RMII,
    PMTP_RGMII
  } pmtp_mode_t;

endpackage : pmtp_pkg

// File: logic/pmtp_link_if.sv
// Transmit pins between the MAC and the PHY, with the resolved clock.
// Assumes the bench supplies the shared reference clock.
`timescale 1ns/1ps
interface pmtp_link_if (
  // Shared reference clock
  input wire logic ref_clk
);
  logic                  tx_clk_dev;
  logic                  tx_clk_dev_oe_n;
  logic                  tx_clk_mac;
  logic                  tx_clk_mac_oe_n;
  logic                  tx_clk;
  logic                  link_clk;
  logic                  tx_ctrl;
  logic [3:0]            tx_d;
  pmtp_pkg::pmtp_mode_t  phy_mode;

  // The pin has a weak pull-down, so it reads low when nobody drives.
  assign tx_clk = !tx_clk_dev_oe_n ? tx_clk_dev :
                  !tx_clk_mac_oe_n ? tx_clk_mac : 1'b0;
  assign link_clk = (phy_mode == pmtp_pkg::PMTP_RMII) ? ref_clk : tx_clk;

  modport device (
    input  link_clk,
    input  tx_ctrl,
    input  tx_d,
    output tx_clk_dev,
    output tx_clk_dev_oe_n,
    output phy_mode
  );

  modport mac (
    input  link_clk,
    output tx_clk_mac,
    output tx_clk_mac_oe_n,
    output tx_ctrl,
    output tx_d
  );
endinterface : pmtp_link_if

// File: logic/pmtp_phy_end.sv
// PHY end of the transmit port: latches straps, makes the MII transmit
// clock, captures the MAC's stream on the link clock and hands bytes to
// the system clock domain.
// Assumes the interface resolves the link clock from the latched mode.
`timescale 1ns/1ps
`include "pmtp_params.svh"
module pmtp_phy_end (
  // System clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // Configuration straps
  input  wire logic [2:0]             strap_val,
  input  wire logic [2:0]             strap_driven,
  // Link
  pmtp_link_if.device                 link,
  // Latched configuration
  output pmtp_pkg::pmtp_mode_t        cfg_mode,
  output logic                        cfg_speed_100,
  output logic                        cfg_latched,
  // Received transmit stream
  output logic [7:0]                  frame_data,
  output logic                        frame_err,
  output logic                        frame_valid,
  output logic                        frame_active,
  output logic                        frame_end
);

  logic [2:0]                 strap_s1;
  logic [2:0]                 strap_s2;
  logic [2:0]                 drv_s1;
  logic [2:0]                 drv_s2;
  logic [2:0]                 next_strap;
  logic [1:0]                 rel_cnt;
  logic [`PMTP_DIV_W-1:0]     div_cnt;
  logic [`PMTP_DIV_W-1:0]     next_div_cnt;
  logic [`PMTP_DIV_W-1:0]     div_period;
  pmtp_pkg::pmtp_mode_t       mode_l1;
  pmtp_pkg::pmtp_mode_t       mode_l2;
  logic                       rst_l1;
  logic                       rst_l2;
  logic [3:0]                 neg_d;
  logic                       neg_er;
  logic                       rg_en;
  logic [3:0]                 rg_lo;
  logic [7:0]                 shreg;
  logic [1:0]                 unit_cnt;
  logic [7:0]                 hold_byte;
  logic                       hold_err;
  logic                       hold_tgl;
  logic                       link_act;
  logic                       tgl_s1;
  logic                       tgl_s2;
  logic                       tgl_s3;
  logic                       act_s1;
  logic                       act_s2;
  logic                       lc_s1;
  logic                       lc_s2;
  logic                       lc_s3;
  logic                       lrst_req;
  logic [2:0]                 lrst_cnt;

  // Straps come from pins, so they pass two flops before use.
  always_ff @(posedge clk) begin
    strap_s1 <= strap_val;
    strap_s2 <= strap_s1;
    drv_s1   <= strap_driven;
    drv_s2   <= drv_s1;
  end

  // An undriven strap falls back to its weak pull value.
  assign next_strap = (drv_s2 & strap_s2) |
                      (~drv_s2 & `PMTP_STRAP_DEFAULT);

  // Latching waits until the synchronisers hold post-reset pin levels.
  always_ff @(posedge clk) begin
    if (reset) begin
      rel_cnt       <= 2'h0;
      cfg_latched   <= 1'b0;
      cfg_mode      <= pmtp_pkg::PMTP_MII;
      cfg_speed_100 <= 1'b1;
    end else if (!cfg_latched) begin
      if (rel_cnt == `PMTP_STRAP_WAIT) begin
        cfg_latched   <= 1'b1;
        cfg_speed_100 <= next_strap[`PMTP_STRAP_SPEED];
        unique case (next_strap[`PMTP_STRAP_MODE_LO +: 2])
          `PMTP_MODE_RMII:  cfg_mode <= pmtp_pkg::PMTP_RMII;
          `PMTP_MODE_RGMII: cfg_mode <= pmtp_pkg::PMTP_RGMII;
          default:          cfg_mode <= pmtp_pkg::PMTP_MII;
        endcase
      end else begin
        rel_cnt <= rel_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      link.phy_mode <= pmtp_pkg::PMTP_MII;
    end else begin
      link.phy_mode <= cfg_mode;
    end
  end

  assign div_period = cfg_speed_100 ? `PMTP_DIV_W'(`PMTP_DIV_100) :
                                      `PMTP_DIV_W'(`PMTP_DIV_10);

  always_comb begin
    if (div_cnt >= div_period - `PMTP_DIV_W'(1)) begin
      next_div_cnt = '0;
    end else begin
      next_div_cnt = div_cnt + `PMTP_DIV_W'(1);
    end
  end

  // Dividing the system clock keeps the output in fixed phase to it.
  // The pin stays undriven until the straps are latched, so the rate
  // never changes within a pulse; all ones makes the first pulse whole.
  always_ff @(posedge clk) begin
    if (reset || !cfg_latched) begin
      div_cnt              <= '1;
      link.tx_clk_dev      <= 1'b0;
      link.tx_clk_dev_oe_n <= 1'b1;
    end else begin
      div_cnt              <= next_div_cnt;
      link.tx_clk_dev      <= next_div_cnt < (div_period >> 1);
      link.tx_clk_dev_oe_n <= cfg_mode != pmtp_pkg::PMTP_MII;
    end
  end

  // The MII and RGMII link clocks are stopped during reset, so the link side is held in
  // reset until enough of its own edges have been seen after latching.
  always_ff @(posedge clk) begin
    lc_s1 <= link.link_clk;
    lc_s2 <= lc_s1;
    lc_s3 <= lc_s2;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lrst_req <= 1'b1;
      lrst_cnt <= 3'h0;
    end else if (lrst_req && cfg_latched && lc_s2 && !lc_s3) begin
      if (lrst_cnt == `PMTP_LINK_RST_EDGES) begin
        lrst_req <= 1'b0;
      end else begin
        lrst_cnt <= lrst_cnt + 3'h1;
      end
    end
  end

  // Mode and reset are levels; two flops carry them to the link side.
  always_ff @(posedge link.link_clk) begin
    mode_l1 <= cfg_mode;
    mode_l2 <= mode_l1;
    rst_l1  <= lrst_req;
    rst_l2  <= rst_l1;
  end

  always_ff @(negedge link.link_clk) begin
    neg_d  <= link.tx_d;
    neg_er <= link.tx_ctrl;
  end

  // Each completed byte is parked in hold_byte and announced by a toggle.
  always_ff @(posedge link.link_clk) begin
    if (rst_l2) begin
      rg_en     <= 1'b0;
      rg_lo     <= 4'h0;
      shreg     <= 8'h00;
      unit_cnt  <= 2'h0;
      hold_byte <= 8'h00;
      hold_err  <= 1'b0;
      hold_tgl  <= 1'b0;
      link_act  <= 1'b0;
    end else begin
      rg_en <= link.tx_ctrl;
      rg_lo <= link.tx_d;
      unique case (mode_l2)
        pmtp_pkg::PMTP_RGMII: begin
          link_act <= rg_en;
          if (rg_en) begin
            hold_byte <= {neg_d, rg_lo};
            hold_err  <= neg_er;
            hold_tgl  <= ~hold_tgl;
          end
        end
        pmtp_pkg::PMTP_RMII: begin
          link_act <= link.tx_ctrl;
          if (link.tx_ctrl) begin
            shreg <= {link.tx_d[1:0], shreg[7:2]};
            unit_cnt <= unit_cnt + 2'h1;
            if (unit_cnt == `PMTP_LAST_RMII) begin
              hold_byte <= {link.tx_d[1:0], shreg[7:2]};
              hold_err  <= 1'b0;
              hold_tgl  <= ~hold_tgl;
            end
          end else begin
            unit_cnt <= 2'h0;
          end
        end
        pmtp_pkg::PMTP_MII: begin
          link_act <= link.tx_ctrl;
          if (link.tx_ctrl) begin
            shreg <= {link.tx_d, shreg[7:4]};
            if (unit_cnt == `PMTP_LAST_MII) begin
              unit_cnt  <= 2'h0;
              hold_byte <= {link.tx_d, shreg[7:4]};
              hold_err  <= 1'b0;
              hold_tgl  <= ~hold_tgl;
            end else begin
              unit_cnt <= unit_cnt + 2'h1;
            end
          end else begin
            unit_cnt <= 2'h0;
          end
        end
        default: begin
          link_act <= 1'b0;
          unit_cnt <= 2'h0;
        end
      endcase
    end
  end

  // A byte arrives at most once per link clock, which is slower than
  // the three system clocks the toggle needs, so hold_byte is stable
  // when it is copied.
  always_ff @(posedge clk) begin
    if (reset) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      act_s1 <= 1'b0;
      act_s2 <= 1'b0;
    end else begin
      tgl_s1 <= hold_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      act_s1 <= link_act;
      act_s2 <= act_s1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      frame_data   <= 8'h00;
      frame_err    <= 1'b0;
      frame_valid  <= 1'b0;
      frame_active <= 1'b0;
      frame_end    <= 1'b0;
    end else begin
      frame_valid  <= tgl_s2 ^ tgl_s3;
      frame_active <= act_s2;
      frame_end    <= frame_active & ~act_s2;
      if (tgl_s2 ^ tgl_s3) begin
        frame_data <= hold_byte;
        frame_err  <= hold_err;
      end
    end
  end

endmodule : pmtp_phy_end

// File: logic/pmtp_mac_end.sv
// MAC end of the transmit port: takes bytes from the user and drives
// transmit control and data, and the transmit clock in RGMII mode.
// Assumes the link clock is far slower than clk when another end makes it.
`timescale 1ns/1ps
`include "pmtp_params.svh"
module pmtp_mac_end (
  // System clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Configuration
  input  pmtp_pkg::pmtp_mode_t       cfg_mode,
  input  wire logic                  cfg_speed_100,
  // Byte stream to send
  input  wire logic [7:0]            in_data,
  input  wire logic                  in_err,
  input  wire logic                  in_last,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  // Link
  pmtp_link_if.mac                   link
);

  logic                    lc_s1;
  logic                    lc_s2;
  logic                    lc_s3;
  logic                    rgmii;
  logic                    tick_lo;
  logic                    tick_hi;
  logic [`PMTP_DIV_W-1:0]  div_cnt;
  logic [`PMTP_DIV_W-1:0]  next_div_cnt;
  logic [`PMTP_DIV_W-1:0]  div_period;
  logic [7:0]              cur;
  logic                    cur_err;
  logic                    cur_last;
  logic                    cur_ok;
  logic                    next_cur_ok;
  logic                    gap;
  logic                    next_gap;
  logic                    take;
  logic                    consume;
  logic [1:0]              unit_idx;
  logic [1:0]              last_unit;
  logic [3:0]              hi_nib;
  logic                    hi_er;

  assign rgmii = cfg_mode == pmtp_pkg::PMTP_RGMII;

  // Outside RGMII the link clock is a foreign pin, sampled twice first.
  // Data then moves a few clk after the rising edge, which limits the
  // link clock to well below a third of clk.
  always_ff @(posedge clk) begin
    lc_s1 <= link.link_clk;
    lc_s2 <= lc_s1;
    lc_s3 <= lc_s2;
  end

  assign div_period = cfg_speed_100 ? `PMTP_DIV_W'(`PMTP_DIV_100) :
                                      `PMTP_DIV_W'(`PMTP_DIV_10);
  assign next_div_cnt = (div_cnt >= div_period - `PMTP_DIV_W'(1)) ?
                        '0 : div_cnt + `PMTP_DIV_W'(1);

  always_ff @(posedge clk) begin
    if (reset) begin
      // All ones makes the first pulse after reset a whole one.
      div_cnt              <= '1;
      link.tx_clk_mac      <= 1'b0;
      link.tx_clk_mac_oe_n <= 1'b1;
    end else begin
      div_cnt              <= next_div_cnt;
      link.tx_clk_mac      <= next_div_cnt < (div_period >> 1);
      link.tx_clk_mac_oe_n <= !rgmii;
    end
  end

  // In RGMII, data moves one clk after each clock edge, clear of both edges.
  assign tick_lo = rgmii ? (div_cnt == (div_period >> 1)) :
                           (lc_s2 & ~lc_s3);
  assign tick_hi = rgmii && (div_cnt == '0);

  always_comb begin
    unique case (cfg_mode)
      pmtp_pkg::PMTP_RMII:  last_unit = `PMTP_LAST_RMII;
      pmtp_pkg::PMTP_RGMII: last_unit = `PMTP_LAST_RGMII;
      default:              last_unit = `PMTP_LAST_MII;
    endcase
    take        = in_valid && in_ready;
    consume     = tick_lo && cur_ok && (unit_idx == last_unit);
    next_cur_ok = take | (cur_ok & ~consume);
    next_gap    = (consume && cur_last) | (gap & ~(tick_lo & ~cur_ok));
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cur      <= 8'h00;
      cur_err  <= 1'b0;
      cur_last <= 1'b0;
      cur_ok   <= 1'b0;
      gap      <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      cur_ok   <= next_cur_ok;
      gap      <= next_gap;
      in_ready <= !next_cur_ok && !next_gap;
      if (take) begin
        cur      <= in_data;
        cur_err  <= in_err;
        cur_last <= in_last;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      unit_idx     <= 2'h0;
      hi_nib       <= 4'h0;
      hi_er        <= 1'b0;
      link.tx_ctrl <= 1'b0;
      link.tx_d    <= 4'h0;
    end else if (tick_lo) begin
      link.tx_ctrl <= cur_ok;
      hi_nib       <= cur_ok ? cur[7:4] : 4'h0;
      hi_er        <= cur_ok & cur_err;
      unit_idx     <= (consume || !cur_ok) ? 2'h0 : unit_idx + 2'h1;
      if (!cur_ok) begin
        link.tx_d <= 4'h0;
      end else if (cfg_mode == pmtp_pkg::PMTP_RMII) begin
        link.tx_d <= {2'h0, cur[{unit_idx, 1'b0} +: 2]};
      end else if (!rgmii && unit_idx[0]) begin
        link.tx_d <= cur[7:4];
      end else begin
        link.tx_d <= cur[3:0];
      end
    end else if (tick_hi) begin
      link.tx_d    <= hi_nib;
      link.tx_ctrl <= hi_er;
    end
  end

endmodule : pmtp_mac_end

// File: tb/pmtp_link_asserts.sv
// Concurrent checks on the transmit pins between the two ends.
// Assumes the system clock samples every pin of the link interface.
`timescale 1ns/1ps
`include "pmtp_params.svh"
module pmtp_link_asserts (
  // System clock and reset
  input wire logic            clk,
  input wire logic            reset,
  // Transmit pins
  input wire logic            tx_clk_dev,
  input wire logic            tx_clk_dev_oe_n,
  input wire logic            tx_clk_mac,
  input wire logic            tx_clk_mac_oe_n,
  input wire logic            tx_clk,
  input wire logic            tx_ctrl,
  input wire logic [3:0]      tx_d,
  input pmtp_pkg::pmtp_mode_t phy_mode
);
  localparam int DIV_FAST = `PMTP_DIV_100;
  localparam int DIV_SLOW = `PMTP_DIV_10;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [7:0] gap;
  logic       gap_ok;
  logic       clk_q;
  logic       rise;
  assign rise = tx_clk && !clk_q;

  always_ff @(posedge clk) begin
    clk_q <= tx_clk;
  end

  // Cycles since the last rise; cleared while nobody drives the pin.
  always_ff @(posedge clk) begin
    if (reset || (tx_clk_dev_oe_n && tx_clk_mac_oe_n)) begin
      gap    <= 8'h00;
      gap_ok <= 1'b0;
    end else if (rise) begin
      gap    <= 8'h01;
      gap_ok <= 1'b1;
    end else if (gap != 8'hff) begin
      gap <= gap + 8'h01;
    end
  end

  mii_clk_rate_a: assert property (
    rise && gap_ok && !tx_clk_dev_oe_n |->
    gap == 8'(DIV_FAST) || gap == 8'(DIV_SLOW)) else $error("bad tx clock");
  rgmii_clk_rate_a: assert property (
    rise && gap_ok && !tx_clk_mac_oe_n |->
    gap == 8'(DIV_FAST) || gap == 8'(DIV_SLOW)) else $error("bad mac clock");
  mii_clk_high_a: assert property (
    rise && !tx_clk_dev_oe_n |-> tx_clk_dev [*2]) else $error("short high");
  rgmii_clk_high_a: assert property (
    rise && !tx_clk_mac_oe_n |-> tx_clk_mac [*2]) else $error("short high");
  rmii_clk_off_a: assert property (
    (phy_mode == pmtp_pkg::PMTP_RMII) [*2] |->
    tx_clk_dev_oe_n && tx_clk_mac_oe_n) else $error("clock pin driven");
  rgmii_dev_quiet_a: assert property (
    (phy_mode == pmtp_pkg::PMTP_RGMII) [*2] |-> tx_clk_dev_oe_n)
    else $error("device drives clock");
  mii_data_hold_a: assert property (
    rise && !tx_clk_dev_oe_n |-> ($stable(tx_d) && $stable(tx_ctrl)) [*2])
    else $error("data moved at edge");
  rmii_upper_zero_a: assert property (
    phy_mode == pmtp_pkg::PMTP_RMII && tx_ctrl |-> tx_d[3:2] == 2'h0)
    else $error("upper data set");

  mii_frame_c: cover property (!tx_clk_dev_oe_n && tx_ctrl);
  rmii_frame_c: cover property (phy_mode == pmtp_pkg::PMTP_RMII && tx_ctrl);
  rgmii_frame_c: cover property (!tx_clk_mac_oe_n && tx_ctrl);
endmodule : pmtp_link_asserts

// File: tb/testbench.sv
// Both ends joined by the link, a byte model per frame, pin checks.
// Assumes straps and MAC settings change only while reset is held.
`timescale 1ns/1ps
`include "pmtp_params.svh"
module testbench;
  logic                 clk = 1'b0;
  logic                 ref_clk = 1'b0;
  logic                 reset = 1'b1;
  logic [2:0]           strap_val = 3'h4;
  logic [2:0]           strap_driven = 3'h7;
  pmtp_pkg::pmtp_mode_t cfg_mode;
  pmtp_pkg::pmtp_mode_t mac_mode = pmtp_pkg::PMTP_MII;
  logic                 mac_speed = 1'b1;
  logic                 cfg_speed_100;
  logic                 cfg_latched;
  logic [7:0]           frame_data;
  logic                 frame_err;
  logic                 frame_valid;
  logic                 frame_active;
  logic                 frame_end;
  logic [7:0]           in_data = 8'h00;
  logic                 in_err = 1'b0;
  logic                 in_last = 1'b0;
  logic                 in_valid = 1'b0;
  logic                 in_ready;
  logic [31:0]          seed = 32'h00011e08;
  logic [8:0]           exq[$];
  logic [8:0]           got[$];
  logic [3:0]           first_nib;
  logic                 in_frame = 1'b0;
  int                   ends = 0;
  int                   fails = 0;
  int                   total_checks = 0;

  always #4 clk = ~clk;
  // The offset keeps reference edges clear of system clock edges.
  initial begin
    #3.3;
    forever #24 ref_clk = ~ref_clk;
  end

  pmtp_link_if u_if (.ref_clk(ref_clk));
  pmtp_phy_end u_pmtp_phy_end (
    .clk(clk), .reset(reset), .strap_val(strap_val),
    .strap_driven(strap_driven), .link(u_if), .cfg_mode(cfg_mode),
    .cfg_speed_100(cfg_speed_100), .cfg_latched(cfg_latched),
    .frame_data(frame_data), .frame_err(frame_err),
    .frame_valid(frame_valid), .frame_active(frame_active),
    .frame_end(frame_end));
  pmtp_mac_end u_pmtp_mac_end (
    .clk(clk), .reset(reset), .cfg_mode(mac_mode),
    .cfg_speed_100(mac_speed), .in_data(in_data), .in_err(in_err),
    .in_last(in_last), .in_valid(in_valid), .in_ready(in_ready),
    .link(u_if));
  pmtp_link_asserts u_pmtp_link_asserts (
    .clk(clk), .reset(reset), .tx_clk_dev(u_if.tx_clk_dev),
    .tx_clk_dev_oe_n(u_if.tx_clk_dev_oe_n), .tx_clk_mac(u_if.tx_clk_mac),
    .tx_clk_mac_oe_n(u_if.tx_clk_mac_oe_n), .tx_clk(u_if.tx_clk),
    .tx_ctrl(u_if.tx_ctrl), .tx_d(u_if.tx_d), .phy_mode(u_if.phy_mode));

  always @(negedge clk) begin
    if (frame_valid === 1'b1)
      got.push_back({frame_err, frame_data});
    if (frame_end === 1'b1)
      ends++;
  end

  always @(posedge u_if.link_clk) begin
    if (u_if.tx_ctrl === 1'b1 && !in_frame)
      first_nib = u_if.tx_d;
    in_frame = (u_if.tx_ctrl === 1'b1);
  end

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Holds the byte until the edge at which in_ready is seen high.
  task automatic send(input logic [7:0] d, input logic e, input logic l);
    int n;
    n = 0;
    in_data <= d;
    in_err <= e;
    in_last <= l;
    in_valid <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (in_ready !== 1'b1 && n < 2000);
    @(posedge clk);
  endtask : send

  task automatic run(input logic [2:0] sv, input logic [2:0] sd, input int nb);
    logic [2:0]           eff;
    pmtp_pkg::pmtp_mode_t em;
    logic [31:0]          r;
    logic [31:0]          eo;
    int                   n;
    time                  t0;
    eff = (sd & sv) | (~sd & `PMTP_STRAP_DEFAULT);
    em = (eff[1:0] == `PMTP_MODE_RMII) ? pmtp_pkg::PMTP_RMII :
         (eff[1:0] == `PMTP_MODE_RGMII) ? pmtp_pkg::PMTP_RGMII :
         pmtp_pkg::PMTP_MII;
    strap_val <= sv;
    strap_driven <= sd;
    mac_mode <= em;
    mac_speed <= eff[2];
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    n = 0;
    while (cfg_latched !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    check(32'(cfg_mode), 32'(em));
    check(32'(cfg_speed_100), 32'(eff[2]));
    repeat (10) @(posedge u_if.link_clk);
    eo = (em == pmtp_pkg::PMTP_MII) ? 32'h1 :
         (em == pmtp_pkg::PMTP_RGMII) ? 32'h2 : 32'h3;
    r = 32'({u_if.tx_clk_dev_oe_n, u_if.tx_clk_mac_oe_n});
    check(r, eo);
    if (em != pmtp_pkg::PMTP_RMII) begin
      @(posedge u_if.tx_clk);
      t0 = $time;
      @(posedge u_if.tx_clk);
      r = 32'(32'h3b9aca00 / (eff[2] ? `PMTP_RATE_100_HZ : `PMTP_RATE_10_HZ));
      check(32'($time - t0), r);
    end
    exq.delete();
    got.delete();
    ends = 0;
    first_nib = 4'hx;
    @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      r = xorshift();
      exq.push_back({(em == pmtp_pkg::PMTP_RGMII) & r[8], r[7:0]});
      send(r[7:0], r[8], i == nb - 1);
    end
    in_valid <= 1'b0;
    n = 0;
    while ((ends < 1 || got.size() < nb) && n < 5000) begin
      @(posedge clk);
      n++;
    end
    check(32'(got.size()), 32'(nb));
    check(32'(ends), 32'h1);
    check(32'(frame_active), 32'h0);
    for (int i = 0; i < nb && i < got.size(); i++)
      check(32'(got[i]), 32'(exq[i]));
    eo = (em == pmtp_pkg::PMTP_RMII) ? 32'(exq[0][1:0]) : 32'(exq[0][3:0]);
    check(32'(first_nib), eo);
    $display("test done: straps %h/%h, %0d bytes", sv, sd, nb);
  endtask : run

  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  initial begin
    run(3'h4, 3'h7, 8);
    run(3'h3, 3'h7, 3);
    run(3'h1, 3'h3, 8);
    run(3'h6, 3'h7, 8);
    run(3'h2, 3'h7, 3);
    run(3'h2, 3'h0, 4);
    results();
  end

  // Generous bound: the six frames need well under a tenth of this.
  initial begin
    #400000;
    fails++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    results();
  end
endmodule : testbench
